// ---- intc_consts.svh ----
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFF_CPU_STATUS 12'h000
`define OFF_CORE_CONTROL 12'h004
`define OFF_INT_CTRL_ONE 12'h008
`define OFF_INT_CTRL_TWO 12'h00c
`define OFF_FLAG_ZERO 12'h010
`define OFF_ENABLE_ZERO 12'h014
`define OFF_PRIO_BASE 12'h020
`define OFF_TRAP_SET 12'h040
`define OFF_ACCEPT_STAT 12'h044
`define OFF_CPU_CTRL 12'h048
// ---------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------
`define LEVEL_LSB 5
`define LEVEL_HIGH_BIT 3
`define NEST_DIS_BIT 15
`define ALT_TABLE_BIT 15
`define INSTR_DISABLE_ACTIVE_BIT 14
`define TRAP_MASK 16'h007e
`define POL_MASK 16'h001f
`define LEVEL_MAX 3'h7
`define RESET_WORD 16'h0000
`endif

// ---- intc_pkg.sv ----
package intc_pkg;
  // Arbitration states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRESENT = 3'b010,
    ST_SERVICE = 3'b100
  } arb_state_t;
  typedef logic [3:0] level_t;
endpackage

// ---- intc_edge_detect.sv ----
`timescale 1ns/1ns
`include "intc_consts.svh"
// Synchronised edge detector for one external request pin
module intc_edge_detect
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  input wire logic falling,
  output logic hit
);
  logic s1_r; // First stage, read only by s2
  logic s2_r; // Second stage
  logic s3_r; // Previous synchronised value

  // ---------------------------------------------------------------
  // Two-stage synchroniser then history
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Polarity 1 falling, 0 rising
  always_comb
  begin
    if (falling)
      hit = s3_r & ~s2_r;
    else
      hit = ~s3_r & s2_r;
  end
endmodule

// ---- intc_arbiter.sv ----
`timescale 1ns/1ns
// Picks the highest-priority eligible source, lowest index on ties
module intc_arbiter
#(
  parameter int N = 16
)
(
  input wire logic [N-1:0] pend,
  input wire logic [N*3-1:0] prio,
  input wire logic [3:0] cur_level,
  output logic found,
  output logic [3:0] idx,
  output logic [2:0] lvl
);
  always_comb
  begin
    found = 1'b0;
    idx = 4'h0;
    lvl = 3'h0;
    // Descending scan, so >= keeps the lowest index among equals
    for (int i = N - 1; i >= 0; i--)
    begin
      if (pend[i] && prio[i*3 +: 3] != 3'h0 &&
          {1'b0, prio[i*3 +: 3]} > cur_level &&
          (!found || prio[i*3 +: 3] >= lvl))
      begin
        found = 1'b1;
        idx = 4'(i);
        lvl = prio[i*3 +: 3];
      end
    end
  end
endmodule

// ---- intc_regs.sv ----
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "intc_consts.svh"
// Functional notes
// - Request flag set by source, software clears
// - One enable bit per source
// - Three-bit priority field per source
// - Sources in natural vector order positions
// - CPU level at status bits 7:5
// - High level bit extends level above 7
// - Level 7 blocks all user interrupts
// - High level bit read-only, resets zero
// - Nesting disable makes level field read-only
// - Nesting disable at control one bit 15
// - Trap flags at control one bits 6:1
// - Alternate table select at control two bit 15
// - Instruction disable indicator at bit 14
// - Polarity one selects falling edge
// - Polarity zero selects rising edge
// - Serial tx flag at flag bit 12
// - Unimplemented bits read zero, ignore writes
// - Present only if priority exceeds CPU level
// - No nesting: acceptance forces level seven
// - Priority zero means source disabled
module intc_regs
#(
  parameter int NSRC = 16,
  parameter int NEXT = 5
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NSRC-1:0] SRC_REQ,
  input wire logic [NEXT-1:0] EXT_PIN,
  output logic IRQ_VALID,
  output logic [3:0] IRQ_INDEX,
  output logic [2:0] IRQ_LEVEL,
  output logic ALT_TABLE,
  output logic [3:0] CPU_LEVEL
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [2:0] cpu_level_field_r; // Status bits 7:5
  logic cpu_level_high_bit_r; // Core control bit 3
  logic nesting_disable_r;
  logic [5:0] trap_flags_r; // Bits 6:1 of control one
  logic alternate_table_select_r;
  logic instr_disable_active_r;
  logic [NEXT-1:0] ext_pol_r;
  logic [NSRC-1:0] flag_r; // Request flag word zero
  logic [NSRC-1:0] enable_r; // Request enable word zero
  logic [NSRC*3-1:0] prio_r; // Packed priority fields
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_valid_r;
  logic [3:0] irq_index_r;
  logic [2:0] irq_level_r;
  logic [3:0] accepted_idx_r;
  logic [2:0] saved_level_r; // Level restored on return
  intc_pkg::arb_state_t state_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic [15:0] wd;
  logic [NEXT-1:0] ext_hit;
  logic [NSRC-1:0] set_vec;
  logic [NSRC-1:0] clr_vec;
  logic found;
  logic [3:0] win_idx;
  logic [2:0] win_lvl;
  logic [3:0] cur_level;
  logic accept;
  logic ret;
  logic [15:0] cpu_ctrl_w; // Core-side command word
  logic in_prio;

  // Access phase only; one wait state, ready is registered
  assign wr_en = PSEL && PENABLE && PWRITE && !pready_r;
  assign rd_en = PSEL && PENABLE && !PWRITE && !pready_r;
  assign wd = PWDATA[15:0];
  assign in_prio = PADDR >= `OFF_PRIO_BASE && PADDR < 12'(`OFF_PRIO_BASE + 4 * ((NSRC + 3) / 4));
  // Effective level: high bit above the three-bit field
  assign cur_level = {cpu_level_high_bit_r, cpu_level_field_r};
  // Core command word: bit0 accept, bit1 return, bit2 instr_disable_active on, bit3 instr_disable_active off
  assign cpu_ctrl_w = (wr_en && PADDR == `OFF_CPU_CTRL) ? wd : 16'h0000;
  assign accept = cpu_ctrl_w[0] && state_r == intc_pkg::ST_PRESENT;
  assign ret = cpu_ctrl_w[1] && state_r == intc_pkg::ST_SERVICE;

  // ---------------------------------------------------------------
  // External edge detectors, one per pin
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NEXT; g++)
    begin : gen_ext
      intc_edge_detect u_edge
      (
        .clk(CLK),
        .arst_n(ARST_N),
        .pin(EXT_PIN[g]),
        .falling(ext_pol_r[g]),
        .hit(ext_hit[g])
      );
    end
  endgenerate

  // External pins feed sources 0..NEXT-1 in vector order
  always_comb
  begin
    set_vec = SRC_REQ;
    set_vec[NEXT-1:0] = SRC_REQ[NEXT-1:0] | ext_hit;
    clr_vec = '0;
    if (wr_en && PADDR == `OFF_FLAG_ZERO)
      clr_vec = ~wd[NSRC-1:0];
  end

  // ---------------------------------------------------------------
  // Request flags: set wins over software clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      flag_r <= '0;
    else
      flag_r <= (flag_r & ~clr_vec) | set_vec;
  end

  // Enables, one bit per source
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      enable_r <= '0;
    else if (wr_en && PADDR == `OFF_ENABLE_ZERO)
      enable_r <= wd[NSRC-1:0];
  end

  // Priority fields, four per word at nibble steps
  generate
    for (g = 0; g < NSRC; g++)
    begin : gen_prio
      always_ff @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
          prio_r[g*3 +: 3] <= 3'h0;
        else if (wr_en && PADDR == 12'(`OFF_PRIO_BASE + 4 * (g / 4)))
          prio_r[g*3 +: 3] <= wd[(g % 4) * 4 +: 3];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // CPU level field with nesting lock and forced level
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cpu_level_field_r <= 3'h0;
      saved_level_r <= 3'h0;
    end
    else if (accept)
    begin
      saved_level_r <= cpu_level_field_r;
      // No nesting: everything masked until return
      cpu_level_field_r <= nesting_disable_r ? `LEVEL_MAX : irq_level_r;
    end
    else if (ret)
      cpu_level_field_r <= saved_level_r;
    else if (wr_en && PADDR == `OFF_CPU_STATUS && !nesting_disable_r)
      cpu_level_field_r <= wd[`LEVEL_LSB +: 3];
  end

  // High level bit: software cannot write it
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      cpu_level_high_bit_r <= 1'b0;
    else if (trap_flags_r != 6'h00)
      cpu_level_high_bit_r <= 1'b1;
    else
      cpu_level_high_bit_r <= 1'b0;
  end

  // Control one: nesting disable and trap flags
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      nesting_disable_r <= 1'b0;
      trap_flags_r <= 6'h00;
    end
    else
    begin
      if (wr_en && PADDR == `OFF_INT_CTRL_ONE)
      begin
        nesting_disable_r <= wd[`NEST_DIS_BIT];
        trap_flags_r <= wd[6:1] | ((wr_en && PADDR == `OFF_TRAP_SET) ? wd[6:1] : 6'h00);
      end
      else if (wr_en && PADDR == `OFF_TRAP_SET)
        trap_flags_r <= trap_flags_r | wd[6:1];
    end
  end

  // Control two: alternate table, indicator, polarity
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      alternate_table_select_r <= 1'b0;
      instr_disable_active_r <= 1'b0;
      ext_pol_r <= '0;
    end
    else
    begin
      if (wr_en && PADDR == `OFF_INT_CTRL_TWO)
      begin
        alternate_table_select_r <= wd[`ALT_TABLE_BIT];
        ext_pol_r <= wd[NEXT-1:0];
      end
      // Indicator driven only by core commands
      if (cpu_ctrl_w[2])
        instr_disable_active_r <= 1'b1;
      else if (cpu_ctrl_w[3])
        instr_disable_active_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Arbitration and presentation
  // ---------------------------------------------------------------
  intc_arbiter #(.N(NSRC)) u_arb
  (
    .pend(flag_r & enable_r),
    .prio(prio_r),
    .cur_level(cur_level),
    .found(found),
    .idx(win_idx),
    .lvl(win_lvl)
  );

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_r <= intc_pkg::ST_IDLE;
      irq_valid_r <= 1'b0;
      irq_index_r <= 4'h0;
      irq_level_r <= 3'h0;
      accepted_idx_r <= 4'h0;
    end
    else
    begin
      case (state_r)
        intc_pkg::ST_IDLE, intc_pkg::ST_PRESENT:
        begin
          if (accept)
          begin
            state_r <= intc_pkg::ST_SERVICE;
            irq_valid_r <= 1'b0;
            accepted_idx_r <= irq_index_r;
          end
          // Level 7 blocks users, instr_disable_active also holds off
          else if (found && !instr_disable_active_r)
          begin
            state_r <= intc_pkg::ST_PRESENT;
            irq_valid_r <= 1'b1;
            irq_index_r <= win_idx;
            irq_level_r <= win_lvl;
          end
          else
          begin
            state_r <= intc_pkg::ST_IDLE;
            irq_valid_r <= 1'b0;
          end
        end
        intc_pkg::ST_SERVICE:
        begin
          // Nesting would need a stack; one level only here
          if (ret)
            state_r <= intc_pkg::ST_IDLE;
        end
        default:
          state_r <= intc_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read mux, unimplemented bits zero
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= PSEL && PENABLE && !pready_r;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      if (rd_en)
      begin
        if (PADDR == `OFF_CPU_STATUS)
          prdata_r[`LEVEL_LSB +: 3] <= cpu_level_field_r;
        else if (PADDR == `OFF_CORE_CONTROL)
          prdata_r[`LEVEL_HIGH_BIT] <= cpu_level_high_bit_r;
        else if (PADDR == `OFF_INT_CTRL_ONE)
          prdata_r[15:0] <= {nesting_disable_r, 8'h00, trap_flags_r, 1'b0};
        else if (PADDR == `OFF_INT_CTRL_TWO)
          prdata_r[15:0] <= {alternate_table_select_r, instr_disable_active_r, 9'h000,
                             ext_pol_r};
        else if (PADDR == `OFF_FLAG_ZERO)
          prdata_r[NSRC-1:0] <= flag_r;
        else if (PADDR == `OFF_ENABLE_ZERO)
          prdata_r[NSRC-1:0] <= enable_r;
        else if (in_prio)
        begin
          for (int i = 0; i < 4; i++)
            if ((PADDR[5:2] - 4'h8) * 4 + i < NSRC)
              prdata_r[i*4 +: 3] <= prio_r[((PADDR[5:2] - 4'h8) * 4 + i) * 3 +: 3];
        end
        else if (PADDR == `OFF_ACCEPT_STAT)
          prdata_r[7:0] <= {1'b0, state_r == intc_pkg::ST_SERVICE, 2'b00, accepted_idx_r};
        else if (PADDR != `OFF_TRAP_SET && PADDR != `OFF_CPU_CTRL)
          pslverr_r <= 1'b1; // Unmapped address
      end
      else if (wr_en && !(PADDR <= `OFF_ENABLE_ZERO || in_prio ||
               PADDR == `OFF_TRAP_SET || PADDR == `OFF_CPU_CTRL))
        pslverr_r <= 1'b1;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign IRQ_VALID = irq_valid_r;
  assign IRQ_INDEX = irq_index_r;
  assign IRQ_LEVEL = irq_level_r;
  assign ALT_TABLE = alternate_table_select_r;
  assign CPU_LEVEL = cur_level;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_level_lock: assert property (@(posedge CLK) disable iff (!ARST_N)
    (nesting_disable_r && !accept && !ret) |=> $stable(cpu_level_field_r))
    else $error("level changed while locked");
  a_force_seven: assert property (@(posedge CLK) disable iff (!ARST_N)
    (accept && nesting_disable_r) |=> cpu_level_field_r == 3'h7)
    else $error("level not forced to seven");
  a_present_gt: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(irq_valid_r) |-> {1'b0, irq_level_r} > $past(cur_level))
    else $error("presented at or below cpu level");
  a_zero_prio: assert property (@(posedge CLK) disable iff (!ARST_N)
    irq_valid_r |-> irq_level_r != 3'h0)
    else $error("level zero presented");
  a_flag_holds: assert property (@(posedge CLK) disable iff (!ARST_N)
    (flag_r[0] && !clr_vec[0]) |=> flag_r[0])
    else $error("flag dropped without clear");
  a_set_wins: assert property (@(posedge CLK) disable iff (!ARST_N)
    set_vec[12] |=> flag_r[12])
    else $error("set lost");
  a_high_bit_ro: assert property (@(posedge CLK) disable iff (!ARST_N)
    (trap_flags_r == 6'h00) |=> !cpu_level_high_bit_r)
    else $error("high bit set by software");
  a_seven_blocks: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cpu_level_field_r == 3'h7 && state_r == intc_pkg::ST_IDLE) |=> !irq_valid_r)
    else $error("user interrupt above level seven");
  a_apb_ready: assert property (@(posedge CLK) disable iff (!ARST_N)
    (PSEL && PENABLE && !pready_r) |=> pready_r)
    else $error("ready late");
  c_present: cover property (@(posedge CLK) disable iff (!ARST_N) $rose(irq_valid_r));
  c_accept: cover property (@(posedge CLK) disable iff (!ARST_N) accept);
  c_return: cover property (@(posedge CLK) disable iff (!ARST_N) ret);
  c_ext_fall: cover property (@(posedge CLK) disable iff (!ARST_N) ext_hit[0] && ext_pol_r[0]);
endmodule

// ---- req_source_model.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Peripheral and external pin request sources
// ---------------------------------------------------------------
module req_source_model
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fire,
  input wire logic [3:0] fire_idx,
  input wire logic [4:0] pin_lvl,
  output logic [15:0] src_req,
  output logic [4:0] ext_pin
);
  // One-cycle request strobe, one source at a time in vector order
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      src_req <= 16'h0000;
    else if (fire)
      src_req <= 16'h0001 << fire_idx;
    else
      src_req <= 16'h0000;
  end
  // Pins are asynchronous to the block; the design synchronises them
  assign ext_pin = pin_lvl;
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "intc_consts.svh"
module testbench;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk = 1'b0; // 8 ns period
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_valid;
  logic [3:0] irq_index;
  logic [2:0] irq_level;
  logic alt_table;
  logic [3:0] cpu_level;
  logic [15:0] src_req;
  logic [4:0] ext_pin;
  logic fire = 1'b0;
  logic [3:0] fire_idx = 4'h0;
  logic [4:0] pin_lvl = 5'h00; // Pins idle low
  logic [31:0] rd; // Last read data
  logic err; // Last error response
  int n_errors = 0;
  int total_checks = 0;
  always #4 clk = ~clk;
  intc_regs dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_REQ(src_req), .EXT_PIN(ext_pin), .IRQ_VALID(irq_valid),
    .IRQ_INDEX(irq_index), .IRQ_LEVEL(irq_level), .ALT_TABLE(alt_table),
    .CPU_LEVEL(cpu_level));
  req_source_model partner (.clk(clk), .arst_n(arst_n), .fire(fire), .fire_idx(fire_idx),
    .pin_lvl(pin_lvl), .src_req(src_req), .ext_pin(ext_pin));
  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer; ready, data and error all taken at one rising edge
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    // Request held until ready is seen high at a rising edge
    while (pready !== 1'b1)
    begin
      n++;
      if (n >= 20)
      begin
        n_errors++;
        give_verdict();
      end
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // Let flag and presentation registers catch up
  task settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task pulse(input logic [3:0] i);
    @(posedge clk);
    fire <= 1'b1;
    fire_idx <= i;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // Synchroniser plus detector need a few cycles
  task pin_to(input logic [4:0] v);
    @(posedge clk);
    pin_lvl <= v;
    repeat (8) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    rdchk(`OFF_CPU_STATUS, 32'h0);
    rdchk(`OFF_CORE_CONTROL, 32'h0);
    rdchk(`OFF_INT_CTRL_ONE, 32'h0);
    rdchk(`OFF_INT_CTRL_TWO, 32'h0);
    rdchk(`OFF_FLAG_ZERO, 32'h0);
    chk(err, 32'h0);
    chk({alt_table, cpu_level, irq_valid}, 32'h0);
  endtask
  task t_fields;
    wr(`OFF_CPU_STATUS, 32'hffffffff);
    rdchk(`OFF_CPU_STATUS, 32'h000000e0);
    wr(`OFF_CORE_CONTROL, 32'hffffffff);
    rdchk(`OFF_CORE_CONTROL, 32'h0);
    wr(`OFF_INT_CTRL_ONE, 32'h0000ffff);
    rdchk(`OFF_INT_CTRL_ONE, 32'h0000807e);
    settle;
    chk(cpu_level, 32'hf);
    // Level field frozen while nesting is off
    wr(`OFF_CPU_STATUS, 32'h0);
    rdchk(`OFF_CPU_STATUS, 32'h000000e0);
    wr(`OFF_INT_CTRL_ONE, 32'h0);
    wr(`OFF_CPU_STATUS, 32'h0);
    rdchk(`OFF_CPU_STATUS, 32'h0);
    chk(cpu_level, 32'h0);
    wr(`OFF_INT_CTRL_TWO, 32'h0000ffff);
    rdchk(`OFF_INT_CTRL_TWO, 32'h0000801f);
    settle;
    chk(alt_table, 32'h1);
    wr(`OFF_INT_CTRL_TWO, 32'h0);
    xfer(12'h0fc, 1'b0, 32'h0);
    chk(err, 32'h1);
    xfer(12'h0fc, 1'b1, 32'hffffffff);
    chk(err, 32'h1);
    // Trap set port raises the high level bit
    wr(`OFF_TRAP_SET, 32'h00000042);
    rdchk(`OFF_INT_CTRL_ONE, 32'h00000042);
    settle;
    rdchk(`OFF_CORE_CONTROL, 32'h00000008);
    chk(cpu_level, 32'h8);
    wr(`OFF_INT_CTRL_ONE, 32'h0);
    settle;
    chk(cpu_level, 32'h0);
  endtask
  task t_flags;
    pulse(4'hc);
    settle;
    rdchk(`OFF_FLAG_ZERO, 32'h00001000);
    wr(`OFF_FLAG_ZERO, 32'h0000ffff);
    rdchk(`OFF_FLAG_ZERO, 32'h00001000);
    wr(`OFF_FLAG_ZERO, 32'h0);
    rdchk(`OFF_FLAG_ZERO, 32'h0);
  endtask
  task t_present;
    wr(`OFF_PRIO_BASE, 32'h00007330);
    wr(`OFF_ENABLE_ZERO, 32'h00000006);
    pulse(4'h2);
    pulse(4'h1);
    pulse(4'h3);
    settle;
    chk({irq_valid, irq_index, irq_level}, 32'h8b);
    wr(`OFF_ENABLE_ZERO, 32'h0000000e);
    for (int l = 0; l < 8; l++)
    begin
      wr(`OFF_CPU_STATUS, 32'(l) << 5);
      settle;
      chk(irq_valid, 32'(l != 7));
    end
    wr(`OFF_CPU_STATUS, 32'h0);
    settle;
    chk({irq_valid, irq_index, irq_level}, 32'h9f);
    wr(`OFF_PRIO_BASE, 32'h00000330);
    settle;
    chk({irq_valid, irq_index, irq_level}, 32'h8b);
    wr(`OFF_ENABLE_ZERO, 32'h0000000c);
    settle;
    chk({irq_valid, irq_index, irq_level}, 32'h93);
  endtask
  task t_accept;
    for (int nd = 0; nd < 2; nd++)
    begin
      pulse(4'h2);
      wr(`OFF_INT_CTRL_ONE, 32'(nd) << 15);
      wr(`OFF_CPU_CTRL, 32'h1);
      settle;
      chk(cpu_level, (nd == 1) ? 32'h7 : 32'h3);
      rdchk(`OFF_ACCEPT_STAT, 32'h42);
      wr(`OFF_CPU_CTRL, 32'h2);
      settle;
      chk(cpu_level, 32'h0);
    end
    wr(`OFF_INT_CTRL_ONE, 32'h0);
    pulse(4'h2);
    wr(`OFF_CPU_CTRL, 32'h4);
    settle;
    chk(irq_valid, 32'h0);
    rdchk(`OFF_INT_CTRL_TWO, 32'h00004000);
    wr(`OFF_CPU_CTRL, 32'h8);
    rdchk(`OFF_INT_CTRL_TWO, 32'h0);
    settle;
    chk(irq_valid, 32'h1);
    wr(`OFF_ENABLE_ZERO, 32'h0);
    wr(`OFF_FLAG_ZERO, 32'h0);
  endtask
  task t_edges;
    pin_to(5'h01);
    rdchk(`OFF_FLAG_ZERO, 32'h1);
    wr(`OFF_FLAG_ZERO, 32'h0);
    pin_to(5'h00);
    rdchk(`OFF_FLAG_ZERO, 32'h0);
    wr(`OFF_INT_CTRL_TWO, 32'h1);
    pin_to(5'h01);
    rdchk(`OFF_FLAG_ZERO, 32'h0);
    pin_to(5'h00);
    rdchk(`OFF_FLAG_ZERO, 32'h1);
  endtask
  // ---------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task give_verdict;
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is a few hundred cycles; this bound is generous
  initial
  begin
    #400000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_flags();
    t_present();
    t_accept();
    t_edges();
    give_verdict();
  end
endmodule
